// [hdl/aoc_top.sv]
// =====================================================================
// Purpose: Automatic operation control with APB register access
// Assumes: Panel pins asynchronous; executor signals on pclk
// Notes:   All outputs registered
// =====================================================================
`timescale 1ns/1ps

module aoc_top
  import aoc_pkg::*;
#(
  parameter int N_AXIS     = 5,
  parameter int FEED_W     = 16,
  parameter int MS_CYC     = MS_CYCLES,
  parameter int ACCEL_STEP = 16
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Panel inputs, asynchronous
  input  wire logic              emergency_stop_in,
  input  wire logic              reset_key_in,
  input  wire logic              alarm_in,
  input  wire logic              seq_search_in,
  input  wire logic [2:0]        mode_in,
  // Executor events, pclk domain
  input  wire logic              block_done_in,
  input  wire logic              mdi_done_in,
  input  wire logic              prog_end_in,
  input  wire logic              reset_proc_done_in,
  input  wire logic [FEED_W-1:0] prog_feed_in,
  input  wire logic [N_AXIS-1:0] axis_pulse_in,
  input  wire logic              misc_func_req,
  input  wire logic              spindle_func_req,
  input  wire logic              tool_func_req,
  // Machine outputs
  output logic [N_AXIS-1:0]      axis_pulse_out,
  output logic [FEED_W-1:0]      feed_rate_out,
  output logic                   misc_func_strobe,
  output logic                   spindle_func_strobe,
  output logic                   tool_func_strobe,
  output logic                   reset_out,
  output logic                   irq
);

  // =====================================================================
  // Functions
  function automatic logic is_auto_mode(input logic [2:0] m);
    is_auto_mode = (m == MODE_MEMORY) || (m == MODE_DNC) || (m == MODE_MDI);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // =====================================================================
  // Declarations
  localparam int SYNC_W = 7;

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic              estop;
  logic              rkey;
  logic              alarm;
  logic              seq_search;
  logic [2:0]        mode;

  aoc_cmd_t          cmd_q;
  aoc_test_t         test_q;
  aoc_stat_t         stat_q;
  logic              lock_q;
  logic [15:0]       dry_feed_q;
  logic [15:0]       rst_hold_q;
  logic [IRQ_W-1:0]  irq_stat_q;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic              lock_echo_q;
  logic              sbk_echo_q;

  aoc_state_t        state_q;
  aoc_state_t        state_d;
  logic [2:0]        start_mode_q;
  logic              cs_prev_q;
  logic              start_edge;
  logic              start_block;
  logic              start_ok;
  logic              hold_cond;
  logic              rst_active;

  logic [31:0]       ms_cnt_q;
  logic              ms_tick_q;
  logic              rst_wait_q;
  logic [15:0]       hold_cnt_q;
  logic              rst_prev_q;

  logic              access;
  logic              wr_en;
  logic [31:0]       rd_word;
  logic              rd_hit;
  logic [IRQ_W-1:0]  events;
  logic [FEED_W-1:0] feed_target;

  // =====================================================================
  // Input synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {mode_in, seq_search_in, alarm_in, reset_key_in, emergency_stop_in};
      sync2_q <= sync1_q;
    end
  end

  assign estop      = sync2_q[0];
  assign rkey       = sync2_q[1];
  assign alarm      = sync2_q[2];
  assign seq_search = sync2_q[3];
  assign mode       = sync2_q[6:4];
  assign rst_active = estop | rkey;

  // =====================================================================
  // Millisecond tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_q  <= '0;
      ms_tick_q <= 1'b0;
    end else if (ms_cnt_q == 32'(MS_CYC - 1)) begin
      ms_cnt_q  <= '0;
      ms_tick_q <= 1'b1;
    end else begin
      ms_cnt_q  <= ms_cnt_q + 32'd1;
      ms_tick_q <= 1'b0;
    end
  end

  // =====================================================================
  // Operation state
  assign start_edge  = cmd_q.cycle_start_in & ~cs_prev_q;
  assign start_block = ~is_auto_mode(mode) | cmd_q.feed_hold_in | estop | rkey | alarm
                     | (state_q == ST_CYCLE) | (state_q == ST_RESET)
                     | test_q.program_restart_in | seq_search;
  assign start_ok    = start_edge & ~start_block;
  assign hold_cond   = cmd_q.feed_hold_in | alarm
                     | (block_done_in & test_q.single_block_in)
                     | (mdi_done_in & (mode == MODE_MDI))
                     | (block_done_in & (mode != start_mode_q));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_STOP: begin
        if (rst_active) begin
          state_d = ST_RESET;
        end else if (start_ok) begin
          state_d = ST_CYCLE;
        end
      end
      ST_CYCLE: begin
        if (rst_active) begin
          state_d = ST_RESET;
        end else if (hold_cond) begin
          state_d = ST_HOLD;
        end else if (prog_end_in) begin
          state_d = ST_STOP;
        end
      end
      ST_HOLD: begin
        // Only reset or a fresh start edge leaves hold
        if (rst_active) begin
          state_d = ST_RESET;
        end else if (start_ok) begin
          state_d = ST_CYCLE;
        end
      end
      ST_RESET: begin
        if (!rst_active && !reset_out) begin
          state_d = ST_STOP;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= ST_STOP;
      start_mode_q <= MODE_EDIT;
      cs_prev_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      cs_prev_q <= cmd_q.cycle_start_in;
      if (start_ok) begin
        start_mode_q <= mode;
      end
    end
  end

  // Lamps follow next state so they change with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
    end else begin
      stat_q                   <= '0;
      stat_q.cycle_start_lamp  <= (state_d == ST_CYCLE);
      stat_q.feed_hold_lamp    <= (state_d == ST_HOLD);
      stat_q.auto_running_flag <= (state_d == ST_CYCLE) | (state_d == ST_HOLD);
    end
  end

  // =====================================================================
  // Reset output stretch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_out  <= 1'b0;
      rst_wait_q <= 1'b0;
      hold_cnt_q <= '0;
      rst_prev_q <= 1'b0;
    end else begin
      rst_prev_q <= reset_out;
      if (rst_active) begin
        reset_out  <= 1'b1;
        rst_wait_q <= 1'b1;
        hold_cnt_q <= rst_hold_q;
      end else if (rst_wait_q) begin
        if (reset_proc_done_in) begin
          rst_wait_q <= 1'b0;
        end
      end else if (reset_out && ms_tick_q) begin
        if (hold_cnt_q == '0) begin
          reset_out <= 1'b0;
        end else begin
          hold_cnt_q <= hold_cnt_q - 16'd1;
        end
      end
    end
  end

  // =====================================================================
  // Function strobes, dropped at once on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misc_func_strobe    <= 1'b0;
      spindle_func_strobe <= 1'b0;
      tool_func_strobe    <= 1'b0;
    end else begin
      misc_func_strobe    <= misc_func_req & ~rst_active & ~reset_out;
      spindle_func_strobe <= spindle_func_req & ~rst_active & ~reset_out;
      tool_func_strobe    <= tool_func_req & ~rst_active & ~reset_out;
    end
  end

  // =====================================================================
  // Axis pulses and feedrate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      axis_pulse_out <= '0;
      lock_echo_q    <= 1'b0;
      sbk_echo_q     <= 1'b0;
    end else begin
      axis_pulse_out <= axis_pulse_in & {N_AXIS{~lock_q}};
      lock_echo_q    <= lock_q;
      sbk_echo_q     <= test_q.single_block_in;
    end
  end

  always_comb begin
    feed_target = '0;
    if (state_q == ST_CYCLE) begin
      if (test_q.dry_run_in && is_auto_mode(mode)) begin
        feed_target = FEED_W'(dry_feed_q);
      end else begin
        feed_target = prog_feed_in;
      end
    end
  end

  // Ramp toward target each ms; stop and reset ramp down to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feed_rate_out <= '0;
    end else if (ms_tick_q) begin
      if (feed_rate_out + FEED_W'(ACCEL_STEP) < feed_target) begin
        feed_rate_out <= feed_rate_out + FEED_W'(ACCEL_STEP);
      end else if (feed_rate_out < feed_target) begin
        feed_rate_out <= feed_target;
      end else if (feed_rate_out > feed_target + FEED_W'(ACCEL_STEP)) begin
        feed_rate_out <= feed_rate_out - FEED_W'(ACCEL_STEP);
      end else begin
        feed_rate_out <= feed_target;
      end
    end
  end

  // =====================================================================
  // APB slave, one wait state
  assign access = psel & penable & ~pready;
  assign wr_en  = psel & penable & pwrite & pready;

  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    if (hit(paddr, OFS_AUTO_CMD)) begin
      rd_word[7:0] = cmd_q;
    end else if (hit(paddr, OFS_AUTO_STAT)) begin
      rd_word[7:0] = stat_q;
    end else if (hit(paddr, OFS_RST_STAT)) begin
      rd_word[RST_OUT_BIT] = reset_out;
    end else if (hit(paddr, OFS_TEST_ECHO)) begin
      rd_word[ECHO_LOCK_BIT] = lock_echo_q;
      rd_word[ECHO_SBK_BIT]  = sbk_echo_q;
    end else if (hit(paddr, OFS_TEST_IN)) begin
      rd_word[7:0] = test_q;
    end else if (hit(paddr, OFS_LOCK_CTRL)) begin
      rd_word[0] = lock_q;
    end else if (hit(paddr, OFS_DRY_FEED)) begin
      rd_word[15:0] = dry_feed_q;
    end else if (hit(paddr, OFS_RST_HOLD)) begin
      rd_word[15:0] = rst_hold_q;
    end else if (hit(paddr, OFS_IRQ_STAT)) begin
      rd_word[IRQ_W-1:0] = irq_stat_q;
    end else if (hit(paddr, OFS_IRQ_MASK)) begin
      rd_word[IRQ_W-1:0] = irq_mask_q;
    end else if (hit(paddr, OFS_STATE)) begin
      rd_word[1:0] = state_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= access;
      pslverr <= access & ~rd_hit;
      prdata  <= (access && !pwrite) ? rd_word : '0;
    end
  end

  // Writable registers, reserved bits kept zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q      <= '0;
      test_q     <= '0;
      lock_q     <= 1'b0;
      dry_feed_q <= DRY_FEED_RST;
      rst_hold_q <= RST_HOLD_RST;
      irq_mask_q <= '0;
    end else if (wr_en) begin
      if (hit(paddr, OFS_AUTO_CMD)) begin
        cmd_q <= pwdata[7:0] & CMD_WR_MASK;
      end
      if (hit(paddr, OFS_TEST_IN)) begin
        test_q <= pwdata[7:0] & TEST_WR_MASK;
      end
      if (hit(paddr, OFS_LOCK_CTRL)) begin
        lock_q <= pwdata[0];
      end
      if (hit(paddr, OFS_DRY_FEED)) begin
        dry_feed_q <= pwdata[15:0];
      end
      if (hit(paddr, OFS_RST_HOLD)) begin
        rst_hold_q <= pwdata[15:0];
      end
      if (hit(paddr, OFS_IRQ_MASK)) begin
        irq_mask_q <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // =====================================================================
  // Interrupts, set wins over write-one clear
  always_comb begin
    events               = '0;
    events[IRQ_START]    = start_ok;
    events[IRQ_REFUSE]   = start_edge & start_block;
    events[IRQ_HOLD]     = (state_d == ST_HOLD) & (state_q != ST_HOLD);
    events[IRQ_RESET]    = (state_d == ST_RESET) & (state_q != ST_RESET);
    events[IRQ_RST_DONE] = rst_prev_q & ~reset_out;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      irq        <= 1'b0;
    end else begin
      if (wr_en && hit(paddr, OFS_IRQ_STAT)) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W-1:0]) | events;
      end else begin
        irq_stat_q <= irq_stat_q | events;
      end
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule

// [inc/aoc_pkg.sv]
// =====================================================================
// Purpose: Constants and types for the automatic operation control block
// Assumes: APB slave, 32-bit data, 125 MHz pclk
// Notes:   Register word offsets are byte addresses
// =====================================================================
package aoc_pkg;

  // =====================================================================
  // Register offsets
  localparam logic [7:0] OFS_AUTO_CMD   = 8'h00;
  localparam logic [7:0] OFS_AUTO_STAT  = 8'h04;
  localparam logic [7:0] OFS_RST_STAT   = 8'h08;
  localparam logic [7:0] OFS_TEST_ECHO  = 8'h0C;
  localparam logic [7:0] OFS_TEST_IN    = 8'h10;
  localparam logic [7:0] OFS_LOCK_CTRL  = 8'h14;
  localparam logic [7:0] OFS_DRY_FEED   = 8'h18;
  localparam logic [7:0] OFS_RST_HOLD   = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h24;
  localparam logic [7:0] OFS_STATE      = 8'h28;

  // =====================================================================
  // Field layouts
  typedef struct packed {
    logic       feed_hold_in;
    logic       cycle_start_in;
    logic [5:0] rsv;
  } aoc_cmd_t;

  typedef struct packed {
    logic       auto_running_flag;
    logic       rsv6;
    logic       cycle_start_lamp;
    logic       feed_hold_lamp;
    logic [3:0] rsv;
  } aoc_stat_t;

  typedef struct packed {
    logic       rsv7;
    logic       program_restart_in;
    logic [2:0] rsv5;
    logic       dry_run_in;
    logic       single_block_in;
    logic       rsv0;
  } aoc_test_t;

  localparam logic [7:0]  CMD_WR_MASK   = 8'hC0;
  localparam logic [7:0]  TEST_WR_MASK  = 8'h46;
  localparam int          RST_OUT_BIT   = 1;
  localparam int          ECHO_LOCK_BIT = 1;
  localparam int          ECHO_SBK_BIT  = 3;
  localparam int          IRQ_W         = 5;
  localparam int          IRQ_START     = 0;
  localparam int          IRQ_REFUSE    = 1;
  localparam int          IRQ_HOLD      = 2;
  localparam int          IRQ_RESET     = 3;
  localparam int          IRQ_RST_DONE  = 4;

  // =====================================================================
  // Reset values
  localparam logic [15:0] DRY_FEED_RST  = 16'h03E8;
  localparam logic [15:0] RST_HOLD_RST  = 16'h0064;

  // =====================================================================
  // Timing
  localparam int          CLK_PERIOD_PS = 8000;
  localparam int          MS_TICK_NS    = 1000000;
  localparam int          MS_CYCLES     = (MS_TICK_NS / CLK_PERIOD_PS) * 1000;

  // =====================================================================
  // States and modes
  typedef enum logic [1:0] {
    ST_STOP  = 2'b00,
    ST_CYCLE = 2'b01,
    ST_HOLD  = 2'b10,
    ST_RESET = 2'b11
  } aoc_state_t;

  typedef enum logic [2:0] {
    MODE_EDIT   = 3'b000,
    MODE_MEMORY = 3'b001,
    MODE_MDI    = 3'b010,
    MODE_DNC    = 3'b011,
    MODE_MANUAL = 3'b100
  } aoc_mode_t;

endpackage

// [tb/aoc_asserts.sv]
// Purpose: Port checks for aoc_top
// Assumes: Reset hold time never programmed to 0
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps

module aoc_asserts #(
  parameter int N_AXIS     = 5,
  parameter int FEED_W     = 16,
  parameter int MS_CYC     = 10,
  parameter int ACCEL_STEP = 16
) (
  // Clock
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Panel and executor
  input wire logic              emergency_stop_in,
  input wire logic              reset_key_in,
  input wire logic [N_AXIS-1:0] axis_pulse_in,
  input wire logic              misc_func_req,
  input wire logic              spindle_func_req,
  input wire logic              tool_func_req,
  // Machine
  input wire logic [N_AXIS-1:0] axis_pulse_out,
  input wire logic [FEED_W-1:0] feed_rate_out,
  input wire logic              misc_func_strobe,
  input wire logic              spindle_func_strobe,
  input wire logic              tool_func_strobe,
  input wire logic              reset_out
);
  logic [2:0]        req_q;
  logic              rst_q;
  logic [FEED_W-1:0] feed_q;
  int                rel_cnt;
  logic [2:0]        stb;

  assign stb = {misc_func_strobe, spindle_func_strobe, tool_func_strobe};

  // =====================================================================
  // Helpers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q  <= 3'h0;
      rst_q  <= 1'b0;
      feed_q <= '0;
    end else begin
      req_q  <= {misc_func_req, spindle_func_req, tool_func_req};
      rst_q  <= reset_out;
      feed_q <= feed_rate_out;
    end
  end

  // Cycles of reset output after both sources released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_cnt <= 0;
    end else begin
      rel_cnt <= (reset_out && !emergency_stop_in && !reset_key_in) ? rel_cnt + 1 : 0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // =====================================================================
  // Properties
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PREADY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr outside completion");
  AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  AST_LOCK_GATE: assert property ((axis_pulse_out & ~$past(axis_pulse_in)) == '0)
    else $error("axis pulse without cause");
  AST_STROBE_CAUSE: assert property ((stb & ~req_q) == 3'h0)
    else $error("strobe without request");
  AST_STROBE_RESET: assert property (reset_out && rst_q |-> stb == 3'h0)
    else $error("strobe during reset");
  AST_ESTOP_RESET: assert property (emergency_stop_in [*4] |=> reset_out)
    else $error("no reset output on emergency stop");
  AST_KEY_RESET: assert property (reset_key_in [*4] |=> reset_out)
    else $error("no reset output on reset key");
  AST_RESET_STRETCH: assert property ($fell(reset_out) |-> rel_cnt >= MS_CYC)
    else $error("reset output not stretched");
  AST_FEED_RAMP: assert property (int'(feed_rate_out) - int'(feed_q) <= ACCEL_STEP
    && int'(feed_q) - int'(feed_rate_out) <= ACCEL_STEP)
    else $error("feed rate jumped");

  COV_RST_FALL: cover property ($fell(reset_out));
  COV_ERR: cover property (pslverr);
  COV_LOCKED: cover property (axis_pulse_in != '0 ##1 axis_pulse_out == '0);
endmodule

bind aoc_top aoc_asserts #(
  .N_AXIS(N_AXIS), .FEED_W(FEED_W), .MS_CYC(MS_CYC), .ACCEL_STEP(ACCEL_STEP)
) i_aoc_chk (
  .pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr, .emergency_stop_in,
  .reset_key_in, .axis_pulse_in, .misc_func_req, .spindle_func_req, .tool_func_req,
  .axis_pulse_out, .feed_rate_out, .misc_func_strobe, .spindle_func_strobe,
  .tool_func_strobe, .reset_out
);

// [tb/aoc_exec_model.sv]
// Purpose: Executor and machine side model
// Assumes: Bench requests block ends one cycle at a time
// Notes:   Motion and function requests are random
`timescale 1ns/1ps

module aoc_exec_model #(
  parameter int N_AXIS = 5
) (
  // Clock
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Requests
  input  wire logic        blk_go,
  input  wire logic        reset_out,
  // Executor
  output logic             block_done_in,
  output logic             reset_proc_done_in,
  output logic [N_AXIS-1:0] axis_pulse_in,
  output logic [2:0]       func_req
);
  logic [2:0] proc_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_done_in <= 1'b0;
      axis_pulse_in <= '0;
      func_req      <= 3'h0;
    end else begin
      block_done_in <= blk_go;
      axis_pulse_in <= N_AXIS'($urandom);
      func_req      <= 3'($urandom);
    end
  end

  // Reset processing takes several cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proc_q <= 3'h0;
    end else begin
      proc_q <= !reset_out ? 3'h0 : proc_q + 3'(proc_q != 3'h7);
    end
  end

  assign reset_proc_done_in = (proc_q == 3'h7);
endmodule

// [tb/auto_operation_control_tb_top.sv]
// Purpose: Self-checking bench for aoc_top
// Assumes: ms tick shortened to 10 cycles
// Notes:   Reads queue expectations, monitor compares
`timescale 1ns/1ps

module auto_operation_control_tb_top;
  import aoc_pkg::*;
  localparam int MSC = 10;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rst_o;
  logic        estop, rkey, alarm, search, blk_go, blk_done, proc_done;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  mode, freq, fstb;
  logic [15:0] pfeed, feed;
  logic [4:0]  ax_in, ax_out;
  logic [32:0] exp_q[$];
  string       name_q[$];
  int          num_errors, tests_run, cyc, n;

  aoc_top #(.MS_CYC(MSC), .ACCEL_STEP(64)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .emergency_stop_in(estop), .reset_key_in(rkey), .alarm_in(alarm),
    .seq_search_in(search), .mode_in(mode), .block_done_in(blk_done),
    .mdi_done_in(1'b0), .prog_end_in(1'b0), .reset_proc_done_in(proc_done),
    .prog_feed_in(pfeed), .axis_pulse_in(ax_in), .misc_func_req(freq[2]),
    .spindle_func_req(freq[1]), .tool_func_req(freq[0]), .axis_pulse_out(ax_out),
    .feed_rate_out(feed), .misc_func_strobe(fstb[2]), .spindle_func_strobe(fstb[1]),
    .tool_func_strobe(fstb[0]), .reset_out(rst_o), .irq
  );

  aoc_exec_model i_exec (
    .pclk, .presetn, .blk_go, .reset_out(rst_o),
    .block_done_in(blk_done), .reset_proc_done_in(proc_done), .axis_pulse_in(ax_in),
    .func_req(freq)
  );

  // =====================================================================
  // Tasks
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] ex);
    tests_run++;
    if (seen !== ex) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    name_q.push_back(nm);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic start();
    wr(OFS_AUTO_CMD, 32'h00);
    wr(OFS_AUTO_CMD, 32'h40);
  endtask

  task automatic blk();
    blk_go <= 1'b1;
    @(posedge pclk);
    blk_go <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic count_ax(output int c);
    c = 0;
    repeat (40) begin
      @(posedge pclk);
      c += int'(ax_out != 5'h0);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // =====================================================================
  // Clock, timeout, read monitor
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      check(name_q.pop_front(), {pslverr, prdata}, exp_q.pop_front());
    end
  end

  // =====================================================================
  // Sequence
  initial begin
    {presetn, psel, penable, pwrite, estop, rkey, alarm, search, blk_go, paddr, pwdata} = '0;
    mode = MODE_EDIT;
    n = $urandom(32'hB8FC2013);
    pfeed = 16'h0100 + 16'($urandom % 512);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd("dry feed", OFS_DRY_FEED, {17'h0, DRY_FEED_RST});
    rd("hold time", OFS_RST_HOLD, {17'h0, RST_HOLD_RST});
    rd("unmapped", 8'h3C, {1'b1, 32'h0});
    wr(OFS_AUTO_STAT, 32'hFF);
    rd("ro status", OFS_AUTO_STAT, 33'h0);
    start();
    rd("edit start", OFS_STATE, {31'h0, ST_STOP});
    $display("defaults and refusal done");
    mode <= MODE_MEMORY;
    wr(OFS_TEST_IN, 32'h40);
    start();
    rd("restart start", OFS_STATE, {31'h0, ST_STOP});
    wr(OFS_TEST_IN, 32'h00);
    start();
    rd("started", OFS_STATE, {31'h0, ST_CYCLE});
    rd("run lamps", OFS_AUTO_STAT, 33'hA0);
    wr(OFS_AUTO_CMD, 32'h80);
    rd("hold lamps", OFS_AUTO_STAT, 33'h90);
    wr(OFS_AUTO_CMD, 32'h00);
    rd("no resume", OFS_STATE, {31'h0, ST_HOLD});
    wr(OFS_AUTO_CMD, 32'h40);
    rd("resumed", OFS_STATE, {31'h0, ST_CYCLE});
    $display("start and hold done");
    wr(OFS_TEST_IN, 32'h02);
    rd("sbk echo", OFS_TEST_ECHO, 33'h08);
    blk();
    rd("sbk stop", OFS_STATE, {31'h0, ST_HOLD});
    wr(OFS_TEST_IN, 32'h00);
    start();
    blk();
    rd("sbk off", OFS_STATE, {31'h0, ST_CYCLE});
    mode <= MODE_DNC;
    repeat (4) @(posedge pclk);
    blk();
    rd("mode change", OFS_STATE, {31'h0, ST_HOLD});
    mode <= MODE_MEMORY;
    $display("single block done");
    rd("irq status", OFS_IRQ_STAT, 33'h07);
    check("irq masked", {32'h0, irq}, 33'h0);
    wr(OFS_IRQ_MASK, 32'h04);
    repeat (3) @(posedge pclk);
    check("irq raised", {32'h0, irq}, 33'h1);
    wr(OFS_IRQ_STAT, 32'h07);
    repeat (3) @(posedge pclk);
    check("irq cleared", {32'h0, irq}, 33'h0);
    start();
    alarm <= 1'b1;
    repeat (5) @(posedge pclk);
    rd("alarm hold", OFS_STATE, {31'h0, ST_HOLD});
    alarm <= 1'b0;
    repeat (4) @(posedge pclk);
    start();
    wr(OFS_DRY_FEED, 32'h0100);
    wr(OFS_TEST_IN, 32'h04);
    repeat (300) @(posedge pclk);
    check("dry feed", {17'h0, feed}, 33'h100);
    wr(OFS_TEST_IN, 32'h00);
    repeat (300) @(posedge pclk);
    check("prog feed", {17'h0, feed}, {17'h0, pfeed});
    wr(OFS_LOCK_CTRL, 32'h1);
    rd("lock echo", OFS_TEST_ECHO, 33'h02);
    count_ax(n);
    check("locked", 33'(n), 33'h0);
    wr(OFS_LOCK_CTRL, 32'h0);
    rd("unlock echo", OFS_TEST_ECHO, 33'h00);
    count_ax(n);
    check("unlocked", {32'h0, n > 0}, 33'h1);
    for (int i = 0; i < 4; i++) begin
      n = $urandom & 32'h6;
      wr(OFS_TEST_IN, 32'(n));
      rd("rand echo", OFS_TEST_ECHO, {29'h0, n[1], 3'h0});
    end
    wr(OFS_TEST_IN, 32'h0);
    $display("test modes and irq done");
    wr(OFS_RST_HOLD, 32'h2);
    for (int i = 0; i < 2; i++) begin
      estop <= (i == 0);
      rkey <= (i == 1);
      repeat (6) @(posedge pclk);
      check("strobes", {30'h0, fstb}, 33'h0);
      rd("reset state", OFS_STATE, {31'h0, ST_RESET});
      rd("reset lamps", OFS_AUTO_STAT, 33'h0);
      rd("reset out", OFS_RST_STAT, 33'h2);
      estop <= 1'b0;
      rkey <= 1'b0;
      n = 0;
      while (rst_o === 1'b1 && n < 500) begin
        @(posedge pclk);
        n++;
      end
      check("stretch", {32'h0, n >= 2 * MSC && n < 500}, 33'h1);
      repeat (3) @(posedge pclk);
      rd("stopped", OFS_STATE, {31'h0, ST_STOP});
      start();
    end
    $display("reset done");
    repeat (4) @(posedge pclk);
    print_verdict();
  end
endmodule
